// ### inc/rmd_pkg.sv
// Package: constants, register map and types of the relay modulator
//
// Behaviour
// - PFM pulses have a fixed on-time; only the off-interval follows the variable.
// - At maximum PFM rate the off-interval equals the on-time.
// - Actuator type selects none, decreasing or increasing part; default none.
// - Increasing part raises the process value, decreasing part lowers it.
// - PWM cycle duration settable up to 999.0 s, default 10.0 s.
// - Cycle duration is kept not less than the shortest turn-on time.
// - Shortest turn-on time from 0.3 s up to cycle duration, default 0.3 s.
// - PWM pulses shorter than the shortest turn-on time are suppressed that cycle.
// - PFM maximum rate settable 1 to 180 per minute, default 60.
// - PFM on-time is derived from the maximum pulse rate.
// - Hold behaviour: freeze, fixed value or ignore; default ignore.
// - Freeze keeps last value, fixed substitutes user value, ignore is unaffected.
// - Relay energized for pulse time, then de-energized for interval time.
// - In PWM the period stays constant; only duty cycle changes.
// - Diagnostic relay is fail-safe: energized without error, off on error.
// - Alarm relay always works fail-safe.
// - As-assigned mode responds only to messages mapped to this relay.
// - Class mode responds to all messages of the selected class; remappable.
// - Default diagnostic mode: as-assigned, failure class for alarm relay.
// - Assigned message list is readable but not writable in that view.
// - Message mapping only possible once function is diagnostics.
package rmd_pkg;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_CYCLE   = 8'h04;
  localparam logic [7:0] REG_MINON   = 8'h08;
  localparam logic [7:0] REG_PFMAX   = 8'h0C;
  localparam logic [7:0] REG_HOLDVAL = 8'h10;
  localparam logic [7:0] REG_MSGMAP  = 8'h14;
  localparam logic [7:0] REG_MAPVIEW = 8'h18;
  localparam logic [7:0] REG_CLASS   = 8'h1C;
  localparam logic [7:0] REG_STATUS  = 8'h20;
  // CTRL field positions
  localparam int CTRL_FUNC_LSB = 0;
  localparam int CTRL_PFM_BIT  = 2;
  localparam int CTRL_ACT_LSB  = 4;
  localparam int CTRL_HOLD_LSB = 6;
  localparam int CTRL_DIAG_LSB = 8;
  // Times in tenths of a second
  localparam longint TICK_NS     = 100_000_000;
  localparam longint CLK_NS      = 50;
  localparam longint TICK_CYC    = TICK_NS / CLK_NS;
  localparam logic [13:0] CYCLE_MAX = 14'h2706;   // 999.0 s
  localparam logic [13:0] CYCLE_RST = 14'h0064;   // 10.0 s
  localparam logic [13:0] MINON_MIN = 14'h0003;   // 0.3 s
  localparam logic [13:0] MINON_RST = 14'h0003;
  localparam logic [7:0]  RATE_MIN  = 8'h01;
  localparam logic [7:0]  RATE_MAX  = 8'hB4;      // 180 per minute
  localparam logic [7:0]  RATE_RST  = 8'h3C;      // 60 per minute
  localparam logic [8:0]  HALF_MIN_TENTHS = 9'h12C; // 30.0 s
  localparam logic [7:0]  MV_FULL   = 8'hFF;
  typedef enum logic [1:0] {FN_OFF, FN_CTRL, FN_DIAG} rmd_func_t;
  typedef enum logic [1:0] {ACT_NONE, ACT_DEC, ACT_INC} rmd_act_t;
  typedef enum logic [1:0] {HOLD_IGNORE, HOLD_FREEZE, HOLD_FIXED} rmd_hold_t;
  typedef enum logic [2:0] {DG_ASSIGNED, DG_MAINT, DG_SPEC, DG_CHECK, DG_FAIL} rmd_diag_t;
  typedef struct packed {
    rmd_diag_t diag;
    rmd_hold_t hold;
    rmd_act_t  act;
    logic      pfm;
    rmd_func_t func;
  } rmd_ctrl_t;
endpackage

// ### rtl/rmd_relay.sv
// Relay modulator and diagnostic relay with AHB-Lite register slave
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rmd_relay
  import rmd_pkg::*;
#(
  parameter int     NMSG     = 8,        // Diagnostic message count
  parameter bit     IS_ALARM = 1'b0,     // Alarm relay instance
  parameter longint TICK_LEN = TICK_CYC  // Clocks per 0.1 s
)(
  input  wire logic              clk,       // 20 MHz clock
  input  wire logic              sys_rst,   // Async reset, high
  input  wire logic              hsel,      // AHB select
  input  wire logic [31:0]       haddr,     // AHB address
  input  wire logic [1:0]        htrans,    // AHB transfer type
  input  wire logic              hwrite,    // AHB write
  input  wire logic [2:0]        hsize,     // AHB size
  input  wire logic [31:0]       hwdata,    // AHB write data
  input  wire logic              hready,    // AHB bus ready
  output logic [31:0]            hrdata,    // AHB read data
  output logic                   hreadyout, // AHB slave ready
  output logic                   hresp,     // AHB response
  input  wire logic signed [8:0] mv_in,     // Bipolar manipulated variable
  input  wire logic              hold_in,   // Hold request
  input  wire logic [NMSG-1:0]   diag_msg,  // Active diagnostic messages
  output logic                   relay_on   // Relay coil drive
);
  // Time base counter is 32 bits wide; message fields fit one register word
  if (NMSG < 1 || NMSG > 16 || TICK_LEN < 1 || TICK_LEN > 64'h0000_0000_FFFF_FFFF)
  begin : g_param_chk
    $error("rmd_relay: unsupported parameters");
  end

  function automatic logic [13:0] clamp14(input logic [13:0] v, input logic [13:0] lo,
                                          input logic [13:0] hi);
    clamp14 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Register word layout of the control fields; bit 3 is spare, so no plain cast
  function automatic rmd_ctrl_t ctrl_from_word(input logic [31:0] w);
    rmd_ctrl_t c;
    c.diag = rmd_diag_t'(w[CTRL_DIAG_LSB +: 3]);
    c.hold = rmd_hold_t'(w[CTRL_HOLD_LSB +: 2]);
    c.act  = rmd_act_t'(w[CTRL_ACT_LSB +: 2]);
    c.pfm  = w[CTRL_PFM_BIT];
    c.func = rmd_func_t'(w[CTRL_FUNC_LSB +: 2]);
    return c;
  endfunction

  function automatic logic [31:0] ctrl_to_word(input rmd_ctrl_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CTRL_DIAG_LSB +: 3] = c.diag;
    w[CTRL_HOLD_LSB +: 2] = c.hold;
    w[CTRL_ACT_LSB +: 2]  = c.act;
    w[CTRL_PFM_BIT]       = c.pfm;
    w[CTRL_FUNC_LSB +: 2] = c.func;
    return w;
  endfunction

  localparam rmd_ctrl_t CTRL_RST = '{diag: IS_ALARM ? DG_FAIL : DG_ASSIGNED,
                                     hold: HOLD_IGNORE, act: ACT_NONE, pfm: 1'b0,
                                     func: IS_ALARM ? FN_DIAG : FN_OFF};

  rmd_ctrl_t         ctrl_r;
  logic [13:0]       cycle_r;
  logic [13:0]       minon_r;
  logic [7:0]        rate_r;
  logic [7:0]        holdval_r;
  logic [NMSG-1:0]   map_r;
  logic [2*NMSG-1:0] class_r;
  logic              wr_pend_r;
  logic [7:0]        wr_addr_r;
  logic [31:0]       wdat;
  rmd_ctrl_t         wctrl;

  // Zero wait state slave; every access answers OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wdat      = hwdata;
  assign wctrl     = ctrl_from_word(wdat);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_r <= hsel & htrans[1] & hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_r    <= CTRL_RST;
      cycle_r   <= CYCLE_RST;
      minon_r   <= MINON_RST;
      rate_r    <= RATE_RST;
      holdval_r <= 8'h00;
      map_r     <= '0;
      class_r   <= '0;
    end
    else if (wr_pend_r)
    begin
      unique case (wr_addr_r)
        REG_CTRL:
        begin
          ctrl_r <= wctrl;
          // Alarm relay stays a fail-safe diagnostic output
          if (IS_ALARM)
            ctrl_r.func <= FN_DIAG;
          else if (wdat[1:0] == 2'h3)
            ctrl_r.func <= FN_OFF;
          if (wdat[10:8] > 3'h4)
            ctrl_r.diag <= ctrl_r.diag;
          if (wdat[7:6] == 2'h3)
            ctrl_r.hold <= ctrl_r.hold;
          if (wdat[5:4] == 2'h3)
            ctrl_r.act <= ctrl_r.act;
        end
        // Each limit is bounded by the other setting
        REG_CYCLE: cycle_r <= clamp14(wdat[13:0], minon_r, CYCLE_MAX);
        REG_MINON: minon_r <= clamp14(wdat[13:0], MINON_MIN, cycle_r);
        REG_PFMAX:
          rate_r <= (wdat[7:0] < RATE_MIN) ? RATE_MIN :
                    ((wdat[7:0] > RATE_MAX) ? RATE_MAX : wdat[7:0]);
        REG_HOLDVAL: holdval_r <= wdat[7:0];
        REG_MSGMAP:
          if (ctrl_r.func == FN_DIAG)
            map_r <= wdat[NMSG-1:0];
        REG_CLASS: class_r <= wdat[2*NMSG-1:0];
        default: ;
      endcase
    end
  end

  // Variable part selection
  logic [7:0] mv_sel;
  logic [8:0] mv_neg;

  assign mv_neg = 9'(-mv_in);

  always_comb
  begin
    mv_sel = 8'h00;
    unique case (ctrl_r.act)
      ACT_INC: mv_sel = mv_in[8] ? 8'h00 : mv_in[7:0];
      ACT_DEC: mv_sel = !mv_in[8] ? 8'h00 :
                        (mv_neg[8] ? MV_FULL : mv_neg[7:0]);
      default: mv_sel = 8'h00;
    endcase
  end

  // Hold handling
  logic [7:0] frz_r;
  logic       hold_d_r;
  logic [7:0] mv_use;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      frz_r    <= 8'h00;
      hold_d_r <= 1'b0;
    end
    else
    begin
      hold_d_r <= hold_in;
      if (!hold_in)
        frz_r <= mv_sel;
    end
  end

  always_comb
  begin
    mv_use = mv_sel;
    if (hold_in && ctrl_r.hold == HOLD_FREEZE)
      mv_use = frz_r;
    else if (hold_in && ctrl_r.hold == HOLD_FIXED)
      mv_use = holdval_r;
  end

  // 0.1 s time base; long count is a parameter so simulation may shorten it
  logic [31:0] pre_r;
  logic        tick;

  assign tick = (pre_r == 32'(TICK_LEN - 1));

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pre_r <= 32'h0000_0000;
    else if (tick)
      pre_r <= 32'h0000_0000;
    else
      pre_r <= pre_r + 32'h0000_0001;
  end

  // Pulse lengths computed at each cycle start, in ticks
  logic [21:0] pwm_prod;
  logic [13:0] pwm_on;
  logic [8:0]  pfm_on;
  logic [17:0] pfm_off;
  logic [17:0] on_len;
  logic [17:0] off_len;

  assign pwm_prod = 22'(mv_use) * 22'(cycle_r);
  assign pfm_on   = 9'(HALF_MIN_TENTHS / 9'(rate_r));
  // Off = on * (2*full - mv) / mv gives off == on at full scale
  assign pfm_off  = (mv_use == 8'h00) ? 18'h00000 :
                    18'((18'(pfm_on) * (18'(2 * MV_FULL) - 18'(mv_use))) / 18'(mv_use));

  always_comb
  begin
    pwm_on = 14'(pwm_prod / 22'(MV_FULL));
    if (pwm_on < minon_r)
      pwm_on = 14'h0000;
    if (ctrl_r.pfm)
    begin
      on_len  = 18'(pfm_on);
      off_len = pfm_off;
    end
    else
    begin
      on_len  = 18'(pwm_on);
      off_len = 18'(cycle_r - pwm_on);
    end
  end

  typedef enum logic [1:0] {MS_IDLE, MS_ON, MS_OFF} rmd_mod_t;
  rmd_mod_t    mst_r;
  logic [17:0] left_r;
  logic [17:0] off_r;
  logic        run;

  assign run = (ctrl_r.func == FN_CTRL) && (ctrl_r.act != ACT_NONE);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mst_r  <= MS_IDLE;
      left_r <= 18'h00000;
      off_r  <= 18'h00000;
    end
    else if (!run)
      mst_r <= MS_IDLE;
    else if (tick)
    begin
      unique case (mst_r)
        MS_IDLE, MS_OFF:
          if (mst_r == MS_OFF && left_r > 18'h00001)
            left_r <= left_r - 18'h00001;
          else if (ctrl_r.pfm && mv_use == 8'h00)
            mst_r <= MS_IDLE;
          else if (on_len == 18'h00000)
          begin
            mst_r  <= MS_OFF;
            left_r <= off_len;
          end
          else
          begin
            mst_r  <= MS_ON;
            left_r <= on_len;
            off_r  <= off_len;
          end
        MS_ON:
          if (left_r > 18'h00001)
            left_r <= left_r - 18'h00001;
          else if (off_r != 18'h00000)
          begin
            mst_r  <= MS_OFF;
            left_r <= off_r;
          end
          else if (ctrl_r.pfm)
            mst_r <= MS_IDLE;
          else if (on_len == 18'h00000)
          begin
            mst_r  <= MS_OFF;
            left_r <= off_len;
          end
          else
          begin
            // Full duty: next cycle starts at once so the period does not stretch
            left_r <= on_len;
            off_r  <= off_len;
          end
      endcase
    end
  end

  // Diagnostic fault evaluation
  logic [NMSG-1:0] cls_hit;
  logic            fault;

  always_comb
  begin
    for (int i = 0; i < NMSG; i++)
      cls_hit[i] = (class_r[2*i +: 2] == 2'(ctrl_r.diag - DG_MAINT));
    if (ctrl_r.diag == DG_ASSIGNED)
      fault = |(diag_msg & map_r);
    else
      fault = |(diag_msg & cls_hit);
  end

  // Fail-safe: coil held on with no error, so power loss also reads as alarm
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      relay_on <= 1'b0;
    else if (ctrl_r.func == FN_DIAG)
      relay_on <= !fault;
    else
      relay_on <= run && (mst_r == MS_ON);
  end

  // Read data registered in the address phase
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      unique case (haddr[7:0])
        REG_CTRL:    hrdata <= ctrl_to_word(ctrl_r);
        REG_CYCLE:   hrdata <= 32'(cycle_r);
        REG_MINON:   hrdata <= 32'(minon_r);
        REG_PFMAX:   hrdata <= 32'(rate_r);
        REG_HOLDVAL: hrdata <= 32'(holdval_r);
        REG_MSGMAP:  hrdata <= 32'(map_r);
        REG_MAPVIEW: hrdata <= 32'(map_r);
        REG_CLASS:   hrdata <= 32'(class_r);
        REG_STATUS:  hrdata <= {12'h000, 1'(hold_d_r), 1'(fault), 2'(mst_r),
                                relay_on, 15'(diag_msg)};
        default:     hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // rmd_relay
`default_nettype wire

// ### tb/rmd_actuator.sv
// Relay-driven actuator model that measures the pulses it receives
`timescale 1ns/1ps
`default_nettype none
module rmd_actuator (
  input  wire logic clk,      // Clock
  input  wire logic relay_on, // Coil drive
  output int        on_len,   // Last on span
  output int        off_len,  // Last off span
  output int        n_pulse   // Pulses done
);
  int   cnt  = 0;
  logic last = 1'h0;
  // Spans in whole clocks; a pulse counts only once it has ended
  always @(posedge clk)
  begin
    last <= relay_on;
    cnt <= (relay_on == last) ? cnt + 1 : 1;
    if (relay_on != last && last)
    begin
      on_len <= cnt;
      n_pulse <= n_pulse + 1;
    end
    if (relay_on != last && !last)
      off_len <= cnt;
  end
endmodule // rmd_actuator
`default_nettype wire

// ### tb/rmd_relay_monitor.sv
// Port checker of the relay modulator, bound into the design
`timescale 1ns/1ps
`default_nettype none
module rmd_relay_monitor
  import rmd_pkg::*;
#(
  parameter int     NMSG     = 8,
  parameter bit     IS_ALARM = 1'b0,
  parameter longint TICK_LEN = 4
)(
  input wire logic            clk,       // Clock
  input wire logic            sys_rst,   // Reset
  input wire logic            hsel,      // Select
  input wire logic [31:0]     haddr,     // Address
  input wire logic [1:0]      htrans,    // Transfer
  input wire logic            hwrite,    // Write
  input wire logic [31:0]     hwdata,    // Write data
  input wire logic            hready,    // Bus ready
  input wire logic [31:0]     hrdata,    // Read data
  input wire logic            hreadyout, // Slave ready
  input wire logic            hresp,     // Response
  input wire logic [NMSG-1:0] diag_msg,  // Messages
  input wire logic            relay_on   // Coil drive
);
  logic [7:0]        a_q;
  logic              w_q, pfm_r;
  logic [1:0]        fn_r, act_r;
  logic [2:0]        dg_r;
  logic [NMSG-1:0]   map_r;
  logic [2*NMSG-1:0] cls_r;
  int                on_cnt;
  wire logic rd_take = hsel && hready && htrans[1] && !hwrite;
  wire logic none_m  = fn_r == FN_CTRL && act_r == 2'h0;
  wire logic off_m   = fn_r == FN_OFF;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Shadow of control fields; assumes the bench writes only legal codes
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      {w_q, a_q, pfm_r, act_r, map_r, cls_r} <= '0;
      // Alarm relay starts as a failure-class diagnostic output
      fn_r <= IS_ALARM ? 2'h2 : 2'h0;
      dg_r <= IS_ALARM ? 3'h4 : 3'h0;
    end
    else
    begin
      w_q <= hsel && hready && htrans[1] && hwrite;
      a_q <= haddr[7:0];
      if (w_q && a_q == REG_CTRL)
        {dg_r, act_r, pfm_r, fn_r} <= {hwdata[10:8], hwdata[5:4], hwdata[2],
                                       IS_ALARM ? 2'h2 : hwdata[1:0]};
      if (w_q && a_q == REG_MSGMAP && fn_r == FN_DIAG)
        map_r <= hwdata[NMSG-1:0];
      if (w_q && a_q == REG_CLASS)
        cls_r <= hwdata[2*NMSG-1:0];
    end
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      on_cnt <= 0;
    else
      on_cnt <= relay_on ? on_cnt + 1 : 0;
  function automatic logic flt(logic [NMSG-1:0] m, mp, logic [2*NMSG-1:0] cl, logic [2:0] dg);
    flt = 1'h0;
    for (int i = 0; i < NMSG; i++)
      if (m[i] && (dg == 3'h0 ? mp[i] : cl[2*i+:2] == dg[1:0] - 2'h1))
        flt = 1'h1;
  endfunction
  // Settings must be steady one cycle, since the relay follows a clock late
  sequence s_diag_held;
    !sys_rst && fn_r == FN_DIAG ##1 fn_r == FN_DIAG && $stable({map_r, cls_r, dg_r});
  endsequence
  sequence s_none_held;
    none_m ##1 none_m;
  endsequence
  a_ready_high: assert property (hreadyout) else $error("hreadyout dropped");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_rdata_hold: assert property (!rd_take |=> $stable(hrdata)) else $error("hrdata moved");
  a_unmapped_zero: assert property (rd_take && haddr[7:0] > 8'h23 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_diag_failsafe:
    assert property (s_diag_held |-> relay_on == !flt($past(diag_msg), map_r, cls_r, dg_r))
    else $error("diagnostic relay level wrong");
  a_none_no_rise:
    assert property (s_none_held |-> !$rose(relay_on)) else $error("pulse without actuator");
  a_pwm_min_on:
    // A pulse cut by deselecting the actuator is not a computed pulse
    assert property ($fell(relay_on) && fn_r == FN_CTRL && act_r != 2'h0 && !pfm_r |->
      on_cnt >= MINON_MIN * TICK_LEN) else $error("pulse below shortest on time");
  a_func_off: assert property (off_m ##1 off_m |-> !relay_on) else $error("relay on while off");
endmodule // rmd_relay_monitor
bind rmd_relay rmd_relay_monitor #(.NMSG(NMSG), .IS_ALARM(IS_ALARM), .TICK_LEN(TICK_LEN)) u_mon (
  .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .diag_msg(diag_msg), .relay_on(relay_on));
`default_nettype wire

// ### tb/rmd_relay_tb.sv
// Self-checking bench of the relay modulator
`timescale 1ns/1ps
`default_nettype none
module rmd_relay_tb;
  import rmd_pkg::*;
  localparam longint TL = 4;
  logic              clk = 1'h0, sys_rst = 1'h1, hwrite = 1'h0, hold_in = 1'h0;
  logic [1:0]        htrans = 2'h0;
  logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic signed [8:0] mv_in = 9'h000;
  logic [7:0]        diag_msg = 8'h00;
  logic              hreadyout, hresp, relay_on, relay_a;
  logic [31:0]       hrdata_a;
  int                on_len, off_len, n_pulse, n_fail = 0, compares = 0, cyc = 0;
  always #25 clk = ~clk;
  rmd_relay #(.NMSG(8), .TICK_LEN(TL)) dut (.clk(clk), .sys_rst(sys_rst), .hsel(1'h1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mv_in(mv_in), .hold_in(hold_in), .diag_msg(diag_msg), .relay_on(relay_on));
  // Alarm relay listens on the same bus; only its read data and coil are watched
  rmd_relay #(.NMSG(8), .IS_ALARM(1'b1), .TICK_LEN(TL)) dut_alarm (.clk(clk),
    .sys_rst(sys_rst), .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata_a), .hreadyout(),
    .hresp(), .mv_in(mv_in), .hold_in(hold_in), .diag_msg(diag_msg), .relay_on(relay_a));
  rmd_actuator act (.clk(clk), .relay_on(relay_on), .on_len(on_len), .off_len(off_len),
    .n_pulse(n_pulse));
  task automatic test_done;
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, exp, string msg);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp, string msg);
    xfer(1'h0, a, 32'h0);
    chk(hrdata, exp, msg);
  endtask
  task automatic t_regs;
    chk(32'(relay_on), 32'h0, "relay idle");
    rd(REG_CTRL, 32'h0, "ctrl");
    chk(hrdata_a, 32'h402, "alarm ctrl");
    chk(32'(relay_a), 32'h1, "alarm idle");
    rd(REG_CYCLE, 32'h64, "cycle");
    rd(REG_MINON, 32'h3, "minon");
    rd(REG_PFMAX, 32'h3C, "rate");
    rd(8'h24, 32'h0, "unmapped");
  endtask
  task automatic t_limits;
    wr(REG_CYCLE, 32'h2710);
    rd(REG_CYCLE, 32'h2706, "cycle max");
    wr(REG_MINON, 32'h1);
    rd(REG_MINON, 32'h3, "minon min");
    wr(REG_CYCLE, 32'h2);
    rd(REG_CYCLE, 32'h3, "cycle floor");
    wr(REG_MINON, 32'h32);
    rd(REG_MINON, 32'h3, "minon ceiling");
    wr(REG_PFMAX, 32'hC8);
    rd(REG_PFMAX, 32'hB4, "rate max");
    wr(REG_CYCLE, 32'hA);
    wr(REG_HOLDVAL, 32'h66);
  endtask
  // Long settle so the pulse measured is never one cut by a change
  task automatic mod_case(logic [31:0] c, r, logic h, logic [8:0] m, int on, off);
    int np;
    wr(REG_CTRL, c);
    wr(REG_PFMAX, r);
    hold_in <= h;
    repeat (8) @(posedge clk);
    mv_in <= m;
    repeat (240) @(posedge clk);
    np = n_pulse;
    repeat (120) @(posedge clk);
    if (on == 0)
      chk(32'(n_pulse - np), 32'h0, "pulse seen");
    else
    begin
      chk(32'(on_len), 32'(on * TL), "on time");
      chk(32'(off_len), 32'(off * TL), "off time");
    end
  endtask
  task automatic t_mod;
    mod_case(32'h21, 32'h3C, 1'h0, 9'h099, 6, 4);
    mod_case(32'h21, 32'h3C, 1'h0, 9'h066, 4, 6);
    mod_case(32'h21, 32'h3C, 1'h0, 9'h033, 0, 0);
    mod_case(32'h11, 32'h3C, 1'h0, 9'h0FF, 0, 0);
    mod_case(32'h11, 32'h3C, 1'h0, 9'h167, 6, 4);
    mod_case(32'h01, 32'h3C, 1'h0, 9'h0FF, 0, 0);
    mod_case(32'h21, 32'h3C, 1'h0, 9'h099, 6, 4);
    mod_case(32'h61, 32'h3C, 1'h1, 9'h033, 6, 4);
    mod_case(32'hA1, 32'h3C, 1'h1, 9'h033, 4, 6);
    mod_case(32'h21, 32'h3C, 1'h1, 9'h0CC, 8, 2);
    mod_case(32'h25, 32'h3C, 1'h0, 9'h0FF, 5, 5);
    mod_case(32'h25, 32'h3C, 1'h0, 9'h0AA, 5, 10);
    mod_case(32'h25, 32'h96, 1'h0, 9'h0FF, 2, 2);
    mod_case(32'h25, 32'h3C, 1'h0, 9'h000, 0, 0);
    chk(32'(relay_a), 32'h1, "alarm kept diag");
  endtask
  task automatic diag_case(logic [7:0] d, logic exp, string msg);
    diag_msg <= d;
    repeat (3) @(posedge clk);
    chk(32'(relay_on), 32'(exp), msg);
  endtask
  task automatic t_diag;
    wr(REG_MSGMAP, 32'h1);
    rd(REG_MAPVIEW, 32'h0, "map outside diag");
    wr(REG_CTRL, 32'h2);
    wr(REG_MSGMAP, 32'h1);
    wr(REG_MAPVIEW, 32'hFF);
    rd(REG_MAPVIEW, 32'h1, "map view");
    diag_case(8'h00, 1'h1, "no error");
    diag_case(8'h02, 1'h1, "unmapped msg");
    diag_case(8'h01, 1'h0, "mapped msg");
    wr(REG_CLASS, 32'hE4);
    for (int m = 1; m < 5; m++)
    begin
      wr(REG_CTRL, 32'h2 | 32'(m << 8));
      diag_case(8'h1 << (m - 1), 1'h0, "class hit");
      diag_case(8'h1 << (m % 4), 1'h1, "class miss");
    end
    wr(REG_CLASS, 32'hE7);
    diag_case(8'h01, 1'h0, "remapped");
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      test_done();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    t_regs();
    t_limits();
    t_mod();
    t_diag();
    test_done();
  end
endmodule // rmd_relay_tb
`default_nettype wire
